/* File: testbench/esc_debug_model.sv */
// Purpose: Debug logic and DMA side of esc_top
// Assumes: Updates just after the rising edge
// Notes:   DMA burst length sets prompt or slow answer
`timescale 1ns/1ps
`default_nettype none
module esc_debug_model (
  input  wire logic       sys_clk_i,
  input  wire logic       halt_req_i,
  input  wire logic       dma_go_i,
  input  wire logic [7:0] dma_len_i,
  output logic            emu_suspend_o,
  output logic            dma_active_o
);
  logic [7:0] left = 8'h0;
  initial emu_suspend_o = 1'b0;
  // Rising edge keeps clear of the bench, which drives on falling edges
  always @(posedge sys_clk_i) begin
    emu_suspend_o <= halt_req_i;
    if (dma_go_i) left <= dma_len_i;
    else if (left != 8'h0) left <= left - 8'h1;
  end
  assign dma_active_o = (left != 8'h0);
endmodule : esc_debug_model
`default_nettype wire

/* File: testbench/esc_properties.sv */
// Purpose: Port checks for esc_top
// Assumes: Bound to every esc_top
// Notes:   Sees top ports only
`timescale 1ns/1ps
`default_nettype none
module esc_properties
  import esc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        emu_suspend_i,
  input wire logic        emu_ack_o,
  input wire logic [3:0]  top_state_i,
  input wire logic        dma_active_i,
  input wire logic        transmit_event_i,
  input wire logic        transmit_dma_event_o,
  input wire logic        receive_dma_event_o,
  input wire logic        mem_err_o,
  input wire logic        dec_int_o,
  input wire logic        core_pause_o,
  input wire logic        mem_access_en_o,
  input wire logic        halted_by_debug_o,
  input wire logic [31:0] status_halt_o
);
  // ====
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ack_quiet: assert property (
    $rose(emu_ack_o) |-> $past(!dma_active_i && top_state_i <= ESC_STATE_ONE))
    else $error("ack rose with core busy");
  a_ack_drop: assert property (
    $fell(emu_suspend_i) |-> ##[1:8] !emu_ack_o)
    else $error("ack stayed after release");
  a_ack_holds: assert property (
    emu_ack_o && emu_suspend_i |=> emu_ack_o) else $error("ack dropped early");
  a_events_gated: assert property (
    halted_by_debug_o && $past(halted_by_debug_o)
    |-> !transmit_dma_event_o && !receive_dma_event_o)
    else $error("event while halted");
  a_tx_follows: assert property (
    !halted_by_debug_o && $past(!halted_by_debug_o)
    |-> transmit_dma_event_o == $past(transmit_event_i))
    else $error("transmit event lost");
  a_err_masked: assert property (
    halted_by_debug_o && $past(halted_by_debug_o && top_state_i == ESC_STATE_ONE)
    |-> !mem_err_o && !dec_int_o) else $error("error while halted");
  a_status_bit: assert property (
    status_halt_o == {21'h0, halted_by_debug_o, 10'h0})
    else $error("status bit wrong");
  a_mem_open: assert property (
    mem_access_en_o == halted_by_debug_o) else $error("memory access gate");
  a_pause_halt: assert property (
    halted_by_debug_o |-> core_pause_o) else $error("halted without pause");
endmodule : esc_properties
bind esc_top esc_properties i_esc_properties (.*);
`default_nettype wire

/* File: testbench/tb_esc_top.sv */
// Purpose: Self-checking bench for esc_top
// Assumes: Inputs change on falling edge
// Notes:   Reads scored through a queue
`timescale 1ns/1ps
`default_nettype none
module tb_esc_top import esc_pkg::*; ;
  logic clk, rst_b, sel, wr, rt, mb, md, fb, tx, fs, me, di, hq, go, rp;
  logic [19:0] adr;
  logic [31:0] wd, rd, st, d, expq[$];
  logic [3:0]  ts;
  logic [7:0]  dl = 8'h0;
  logic ack, cp, rxo, txo, fso, meo, dio, mae, hb, su, dma;
  int errors = 0, tests_run = 0, seed = 55129;
  esc_debug_model i_esc_debug_model (.sys_clk_i(clk), .halt_req_i(hq),
    .dma_go_i(go), .dma_len_i(dl), .emu_suspend_o(su), .dma_active_o(dma));
  esc_top i_esc_top (.sys_clk_i(clk), .rst_b_i(rst_b), .cfg_sel_i(sel),
    .cfg_wr_i(wr), .cfg_addr_i(adr), .cfg_wdata_i(wd), .cfg_rdata_o(rd),
    .emu_suspend_i(su), .realtime_suspend_request_i(rt), .emu_ack_o(ack),
    .top_state_i(ts), .map_busy_i(mb), .map_done_i(md), .frame_busy_i(fb),
    .last_xmit_pending_i(1'b0), .bus_busy_i(rp), .dma_active_i(dma),
    .req_pending_i(rp), .receive_dma_event_i(tx), .transmit_event_i(tx),
    .frame_sync_i(fs), .mem_err_i(me), .dec_int_i(di), .core_pause_o(cp),
    .receive_dma_event_o(rxo), .transmit_dma_event_o(txo),
    .frame_sync_o(fso), .mem_err_o(meo), .dec_int_o(dio),
    .mem_access_en_o(mae), .halted_by_debug_o(hb), .status_halt_o(st));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====
  // Tasks
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task results;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic bus(logic w, logic [19:0] a, logic [31:0] v, logic [31:0] e);
    @(negedge clk);
    {sel, wr, adr, wd} = {1'b1, w, a, v};
    if (!w) expq.push_back(e);
    @(negedge clk);
    sel = 1'b0;
  endtask : bus
  task automatic wack(logic e, int n);
    for (int i = 0; i < n && ack !== e; i++) @(negedge clk);
  endtask : wack
  // Read data stands one cycle after the request edge
  logic rdp = 1'b0;
  always @(posedge clk) begin
    rdp <= sel && !wr;
  end
  // Checked mid-cycle, away from the edge that launches it
  always @(negedge clk) begin
    if (rdp) chk("rdata", rd, expq.pop_front());
  end
  initial begin
    #50us;
    errors++;
    results();
  end
  // ====
  // Sequence
  initial begin
    {sel, wr, rt, mb, md, fb, tx, fs, me, di, hq, go, rp} = '0;
    {adr, wd, ts, rst_b} = '0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    d = $random(seed);
    bus(1'b0, ESC_CTRL_OFFSET, 32'h0, 32'h0);
    bus(1'b1, ESC_CTRL_OFFSET, d | 32'h4, 32'h0);
    bus(1'b0, ESC_CTRL_OFFSET, 32'h0, d & 32'h3);
    bus(1'b1, 20'h00074, 32'h3, 32'h0);
    bus(1'b0, 20'h00074, 32'h0, 32'h0);
    bus(1'b0, ESC_CTRL_OFFSET, 32'h0, d & 32'h3);
    bus(1'b1, ESC_CTRL_OFFSET, 32'h1, 32'h0);
    {hq, rt} = 2'h3;
    repeat (30) @(negedge clk);
    chk("ack free", ack, 32'h0);
    chk("pause free", cp, 32'h0);
    hq = 1'b0;
    repeat (20) begin
      @(negedge clk);
      {tx, me, di} = 3'($random(seed));
    end
    {tx, me, di} = '0;
    bus(1'b1, ESC_CTRL_OFFSET, 32'h0, 32'h0);
    {mb, md, go, dl} = {3'h7, 8'h28};
    @(negedge clk);
    {go, hq} = 2'h1;
    repeat (20) @(negedge clk);
    chk("ack map", ack, 32'h0);
    mb = 1'b0;
    repeat (10) @(negedge clk);
    chk("ack dma", ack, 32'h0);
    wack(1'b1, 40);
    chk("ack gran0", ack, 32'h1);
    // Status flag trails the acknowledge by one cycle
    @(negedge clk);
    chk("status", st, 32'h400);
    chk("pause", cp, 32'h1);
    {tx, me, di, ts} = {3'h7, ESC_STATE_ONE};
    repeat (3) @(negedge clk);
    chk("tx rx", {txo, rxo}, 32'h0);
    chk("err", {meo, dio}, 32'h0);
    chk("mem", mae, 32'h1);
    {tx, me, di, ts, hq} = '0;
    wack(1'b0, 12);
    @(negedge clk);
    chk("release", {ack, hb}, 32'h0);
    bus(1'b1, ESC_CTRL_OFFSET, 32'h2, 32'h0);
    {fb, hq} = 2'h3;
    repeat (20) @(negedge clk);
    chk("ack frame", ack, 32'h0);
    // Frame done, but bus traffic and an event still pending
    {fb, rp, tx} = 3'h3;
    repeat (5) @(negedge clk);
    chk("ack traffic", ack, 32'h0);
    {rp, tx} = 2'h0;
    wack(1'b1, 30);
    chk("ack gran1", ack, 32'h1);
    fs = 1'b1;
    repeat (2) @(negedge clk);
    chk("sync held", fso, 32'h0);
    {fs, hq} = '0;
    wack(1'b0, 12);
    fs = 1'b1;
    repeat (2) @(negedge clk);
    chk("sync free", fso, 32'h1);
    fs = 1'b0;
    {ts, hq} = {ESC_STATE_LAST, 1'b1};
    repeat (20) @(negedge clk);
    chk("ack s14", ack, 32'h0);
    ts = ESC_STATE_IDLE;
    wack(1'b1, 30);
    chk("ack s0", ack, 32'h1);
    hq = 1'b0;
    wack(1'b0, 12);
    results();
  end
endmodule : tb_esc_top
`default_nettype wire

/* File: verilog/esc_ctrl_reg.sv */
// Purpose: Debug halt control register on the configuration bus
// Assumes: Single-cycle writes and reads, read data registered
// Notes:   Only two bits are stored
`timescale 1ns/1ps
`default_nettype none
module esc_ctrl_reg
  import esc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        cfg_sel_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [19:0] cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             run_free_o,
  output logic             gran_sel_o
);
  logic [1:0] ctrl;
  wire        hit = cfg_sel_i && (cfg_addr_i == ESC_CTRL_OFFSET);
  // Bit 2 is deliberately not stored: no realtime select exists
  wire [1:0]  next_ctrl = {cfg_wdata_i[ESC_GRAN_POS],
                           cfg_wdata_i[ESC_RUN_FREE_POS]}; // R2 R17
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= ESC_CTRL_RESET; // R1
    end else if (hit && cfg_wr_i) begin
      ctrl <= next_ctrl; // R1
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_rdata_o <= 32'h0;
    end else if (hit && !cfg_wr_i) begin
      cfg_rdata_o <= {30'h0, ctrl}; // R2
    end else begin
      cfg_rdata_o <= 32'h0;
    end
  end
  assign run_free_o = ctrl[ESC_RUN_FREE_POS];
  assign gran_sel_o = ctrl[ESC_GRAN_POS];
endmodule : esc_ctrl_reg
`default_nettype wire

/* File: verilog/esc_pkg.sv */
// Purpose: Constants for the emulation suspend control block
// Assumes: 32-bit configuration bus, byte addressed, one word per register
// Notes:   Behaviour list below
//
// Behaviour
// R1 - Control register at 0x00070, run-free bit 0, granularity bit 1, reset 0
// R2 - Reserved control bits read zero, writes to them ignored
// R3 - Run-free set: halts ignored, granularity bit has no effect
// R4 - Run-free clear: halt suspends per granularity select
// R5 - Granularity 0: halt at MAP pass end or before last transmit; MAP wins
// R6 - Granularity 0: MAP processing in progress finishes before suspension
// R7 - Granularity 0 with request held: pause after each MAP pass
// R8 - Bus transfer and pending CPU/DMA requests complete before halt
// R9 - Active receive or transmit event is serviced before suspension
// R10 - While halted no new CPU/DMA events; ongoing accesses may finish
// R11 - On release resume from halt and run until next halt
// R12 - Granularity 1: finish ongoing frame and its requests, then pause
// R13 - Granularity 1: new frame sync held during request; start next on release
// R14 - Top state 14: request ignored until state 0 reached
// R15 - States 0 or 1: acknowledge only when no DMA transfers active
// R16 - State 1 with acknowledge: memory access sets no error, no interrupt
// R17 - Realtime suspend input ignored; control bit 2 reserved
// R18 - In emulation mode internal memories may be read and written
// R19 - Status bit 10 shows halted by debug
// R20 - Request is a held level; acknowledge drops after request drops
package esc_pkg;
  localparam logic [19:0] ESC_CTRL_OFFSET  = 20'h00070;
  localparam int          ESC_RUN_FREE_POS = 0;
  localparam int          ESC_GRAN_POS     = 1;
  localparam logic [1:0]  ESC_CTRL_RESET   = 2'h0;
  localparam int          ESC_HALTED_POS   = 10;
  localparam logic [3:0]  ESC_STATE_IDLE   = 4'h0;
  localparam logic [3:0]  ESC_STATE_ONE    = 4'h1;
  localparam logic [3:0]  ESC_STATE_LAST   = 4'he;

  typedef enum logic [3:0] {
    ESC_RUN    = 4'b0001,
    ESC_DRAIN  = 4'b0010,
    ESC_WAIT   = 4'b0100,
    ESC_HALTED = 4'b1000
  } esc_state_t;
endpackage : esc_pkg

/* File: verilog/esc_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is a slow level
// Notes:   Output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module esc_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule : esc_sync
`default_nettype wire

/* File: verilog/esc_top.sv */
// Purpose: Emulation suspend control for the decoder coprocessor
// Assumes: Decoder core reports state, MAP pass and frame boundaries
// Notes:   Suspend request arrives from another domain and is synchronised
`timescale 1ns/1ps
`default_nettype none
module esc_top
  import esc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // Configuration bus
  input  wire logic        cfg_sel_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [19:0] cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  // Debug logic
  input  wire logic        emu_suspend_i,
  input  wire logic        realtime_suspend_request_i,
  output logic             emu_ack_o,
  // Decoder core status
  input  wire logic [3:0]  top_state_i,
  input  wire logic        map_busy_i,
  input  wire logic        map_done_i,
  input  wire logic        frame_busy_i,
  input  wire logic        last_xmit_pending_i,
  input  wire logic        bus_busy_i,
  input  wire logic        dma_active_i,
  input  wire logic        req_pending_i,
  input  wire logic        receive_dma_event_i,
  input  wire logic        transmit_event_i,
  input  wire logic        frame_sync_i,
  input  wire logic        mem_err_i,
  input  wire logic        dec_int_i,
  // Gated outputs to the core and system
  output logic             core_pause_o,
  output logic             receive_dma_event_o,
  output logic             transmit_dma_event_o,
  output logic             frame_sync_o,
  output logic             mem_err_o,
  output logic             dec_int_o,
  output logic             mem_access_en_o,
  output logic             halted_by_debug_o,
  output logic [31:0]      status_halt_o
);
  // ======================================================
  // Register and request input
  // ======================================================
  logic run_free;
  logic gran_sel;
  logic susp_req;

  esc_ctrl_reg i_esc_ctrl_reg (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .cfg_sel_i   (cfg_sel_i),
    .cfg_wr_i    (cfg_wr_i),
    .cfg_addr_i  (cfg_addr_i),
    .cfg_wdata_i (cfg_wdata_i),
    .cfg_rdata_o (cfg_rdata_o),
    .run_free_o  (run_free),
    .gran_sel_o  (gran_sel)
  );

  esc_sync i_esc_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (emu_suspend_i),
    .level_o   (susp_req)
  );

  // Realtime suspend has no function here
  wire unused_rt = realtime_suspend_request_i; // R17

  // ======================================================
  // Suspend decision
  // ======================================================
  esc_state_t state;
  esc_state_t next_state;

  // Run-free masks the request entirely
  wire halt_req   = susp_req && !run_free; // R3 R4
  wire in_last    = (top_state_i == ESC_STATE_LAST); // R14
  wire in_quiet   = (top_state_i == ESC_STATE_IDLE) ||
                    (top_state_i == ESC_STATE_ONE);
  wire traffic    = bus_busy_i || req_pending_i ||
                    receive_dma_event_i || transmit_event_i; // R8 R9
  // MAP pass end beats the pre-last-transmit point
  wire map_point  = !map_busy_i && map_done_i; // R5 R6 R7
  wire xmit_point = last_xmit_pending_i && !map_busy_i; // R5
  wire soft_point = map_point || xmit_point; // R5
  wire frame_point = !frame_busy_i && !last_xmit_pending_i; // R12
  wire stop_point = gran_sel ? frame_point : soft_point;
  wire may_ack    = in_quiet && !dma_active_i && !traffic; // R15

  always_comb begin
    next_state = state;
    case (state)
      ESC_RUN: begin
        if (halt_req && !in_last) begin
          next_state = ESC_DRAIN; // R14
        end
      end
      ESC_DRAIN: begin
        if (!halt_req) begin
          next_state = ESC_RUN;
        end else if (stop_point && !in_last) begin
          next_state = ESC_WAIT; // R6 R12
        end
      end
      ESC_WAIT: begin
        if (!halt_req) begin
          next_state = ESC_RUN;
        end else if (may_ack) begin
          next_state = ESC_HALTED; // R8 R15
        end
      end
      ESC_HALTED: begin
        if (!halt_req) begin
          next_state = ESC_RUN; // R11 R20
        end
      end
      default: begin
        next_state = ESC_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ESC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ======================================================
  // Gating of events and outputs
  // ======================================================
  wire halted   = (state == ESC_HALTED);
  // Pause holds the core from the stop point onward
  wire pausing  = (state == ESC_WAIT) || halted; // R7 R12
  // Events are blocked only once halted so drains can complete
  wire hold_evt = halted; // R10
  wire hold_sync = halt_req && gran_sel &&
                   (state != ESC_RUN); // R13
  wire quiet_mem = halted && (top_state_i == ESC_STATE_ONE); // R16

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      emu_ack_o            <= 1'b0;
      core_pause_o         <= 1'b0;
      receive_dma_event_o  <= 1'b0;
      transmit_dma_event_o <= 1'b0;
      frame_sync_o         <= 1'b0;
      mem_err_o            <= 1'b0;
      dec_int_o            <= 1'b0;
      mem_access_en_o      <= 1'b0;
      halted_by_debug_o    <= 1'b0;
    end else begin
      emu_ack_o            <= (next_state == ESC_HALTED); // R15 R20
      core_pause_o         <= pausing; // R7 R11
      receive_dma_event_o  <= receive_dma_event_i && !hold_evt; // R10
      transmit_dma_event_o <= transmit_event_i && !hold_evt; // R10
      frame_sync_o         <= frame_sync_i && !hold_sync; // R13
      mem_err_o            <= mem_err_i && !quiet_mem; // R16
      dec_int_o            <= dec_int_i && !quiet_mem; // R16
      mem_access_en_o      <= halted; // R18
      halted_by_debug_o    <= halted; // R19
    end
  end

  assign status_halt_o = {21'h0, halted_by_debug_o, 10'h0}; // R19
endmodule : esc_top
`default_nettype wire
